// ---- hdl/tcw_channel.sv ----
// timer channel: counter, compare/capture, outputs, status and bus slave
`timescale 1ns/1ps
module tcw_channel (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // channel pins
  input  wire logic        wave_out_a_i,
  output logic             wave_out_a_o,
  output logic             wave_out_a_oe_n_o,
  input  wire logic        wave_out_b_i,
  output logic             wave_out_b_o,
  output logic             wave_out_b_oe_n_o,
  input  wire logic        ext_trig_i
);
  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] mode;
    logic [15:0] count;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic        clk_on;
    logic [7:0]  flags;
    logic        a_unread;
    logic        b_unread;
    logic [2:0]  sync_a;
    logic [2:0]  sync_b;
    logic [2:0]  sync_e;
    logic        oe_n;
  } tcw_top_st_t;

  tcw_top_st_t st_ff;
  tcw_top_st_t nxt_st;
  logic        wave;
  logic        wr_fire;
  logic        rd_fire;
  logic        sr_read;
  logic        sw_trig;
  logic        ovf_evt;
  logic        a_cmp;
  logic        b_cmp;
  logic        c_cmp;
  logic        ld_a;
  logic        ld_b;
  logic        ext_evt;
  logic        lovr_evt;
  logic        mir_a;
  logic        mir_b;
  logic [15:0] cnt_inc;
  logic [15:0] old16;
  logic [31:0] wr16;
  logic [31:0] rd_val;
  logic [7:0]  flag_vis;
  logic [7:0]  evts;

  tcw_act_if   ia ();
  tcw_act_if   ib ();

  // merge write data into a word under the byte enables
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      apply_strb[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // selected edge between previous and current synced level
  function automatic logic edge_hit(input logic [1:0] sel, input logic prv, input logic cur);
    unique case (sel)
      tcw_pkg::EDGE_NONE: edge_hit = 1'b0;
      tcw_pkg::EDGE_RISE: edge_hit = !prv && cur;
      tcw_pkg::EDGE_FALL: edge_hit = prv && !cur;
      tcw_pkg::EDGE_BOTH: edge_hit = prv != cur;
    endcase
  endfunction

  // event decode from current state
  always_comb begin
    wave     = st_ff.mode[tcw_pkg::MODE_WAVE];
    wr_fire  = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    rd_fire  = s_axi_arvalid_i && st_ff.arready;
    sr_read  = rd_fire && s_axi_araddr_i == tcw_pkg::ADDR_SR;
    sw_trig  = wr_fire && st_ff.aw_addr == tcw_pkg::ADDR_CTRL && st_ff.w_strb[0]
               && st_ff.w_data[tcw_pkg::CMD_SW_TRIG];
    cnt_inc  = st_ff.count + tcw_pkg::CNT_ONE;
    ovf_evt  = st_ff.clk_on && st_ff.count == tcw_pkg::CNT_MAX;
    a_cmp    = wave && st_ff.clk_on && cnt_inc == st_ff.ra;
    b_cmp    = wave && st_ff.clk_on && cnt_inc == st_ff.rb;
    c_cmp    = st_ff.clk_on && cnt_inc == st_ff.rc;
    // capture loads flagged
    // both loads follow edges of pin a in capture mode
    ld_a     = !wave && edge_hit(st_ff.mode[tcw_pkg::MODE_LDA +: 2], st_ff.sync_a[2],
                                 st_ff.sync_a[1]);
    ld_b     = !wave && edge_hit(st_ff.mode[tcw_pkg::MODE_LDB +: 2], st_ff.sync_a[2],
                                 st_ff.sync_a[1]);
    ext_evt  = edge_hit(st_ff.mode[tcw_pkg::MODE_EXT +: 2], st_ff.sync_e[2], st_ff.sync_e[1]);
    lovr_evt = (ld_a && st_ff.a_unread && !(rd_fire && s_axi_araddr_i == tcw_pkg::ADDR_RA))
            || (ld_b && st_ff.b_unread && !(rd_fire && s_axi_araddr_i == tcw_pkg::ADDR_RB));
    evts     = {ext_evt, ld_b, ld_a, c_cmp, b_cmp, a_cmp, lovr_evt, ovf_evt};
    // mirror pin in capture, driven level in waveform
    mir_a    = wave ? ia.level : st_ff.sync_a[1];
    mir_b    = wave ? ib.level : st_ff.sync_b[1];
    flag_vis = st_ff.flags & ~(wave ? tcw_pkg::FLG_CAPT_ONLY : tcw_pkg::FLG_WAVE_ONLY);
  end

  // read mux and write merge
  always_comb begin
    rd_val = 32'h0;
    unique case (s_axi_araddr_i)
      tcw_pkg::ADDR_MODE: rd_val = st_ff.mode;
      tcw_pkg::ADDR_CV:   rd_val = {16'h0, st_ff.count};
      tcw_pkg::ADDR_RA:   rd_val = {16'h0, st_ff.ra};
      tcw_pkg::ADDR_RB:   rd_val = {16'h0, st_ff.rb};
      tcw_pkg::ADDR_RC:   rd_val = {16'h0, st_ff.rc};
      tcw_pkg::ADDR_SR:   rd_val = {13'h0, mir_b, mir_a, st_ff.clk_on, 8'h0, flag_vis};
      default:            rd_val = 32'h0;
    endcase
    unique case (st_ff.aw_addr)
      tcw_pkg::ADDR_RA: old16 = st_ff.ra;
      tcw_pkg::ADDR_RB: old16 = st_ff.rb;
      default:          old16 = st_ff.rc;
    endcase
    wr16 = apply_strb({16'h0, old16}, st_ff.w_data, st_ff.w_strb);
  end

  // next state
  always_comb begin
    nxt_st        = st_ff;
    // synchronisers: bit 0 first flop, bit 1 second, bit 2 previous
    nxt_st.sync_a = {st_ff.sync_a[1:0], wave_out_a_i};
    nxt_st.sync_b = {st_ff.sync_b[1:0], wave_out_b_i};
    nxt_st.sync_e = {st_ff.sync_e[1:0], ext_trig_i};
    nxt_st.oe_n   = !wave;
    // write address and data taken in either order
    if (s_axi_awvalid_i && st_ff.awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_ff.wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = s_axi_wdata_i;
      nxt_st.w_strb = s_axi_wstrb_i;
    end
    if (st_ff.bvalid && s_axi_bready_i) begin
      nxt_st.bvalid = 1'b0;
    end
    // counter runs every cycle while its clock is on
    if (st_ff.clk_on) begin
      nxt_st.count = cnt_inc;
    end
    if (wr_fire) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have  = 1'b0;
      nxt_st.bvalid  = 1'b1;
      nxt_st.bresp   = tcw_pkg::RESP_OKAY;
      unique case (st_ff.aw_addr)
        tcw_pkg::ADDR_CTRL: begin
          // disable beats enable and trigger start
          if (st_ff.w_strb[0] && st_ff.w_data[tcw_pkg::CMD_CLK_DIS]) begin
            nxt_st.clk_on = 1'b0;
          end else if (st_ff.w_strb[0] && (st_ff.w_data[tcw_pkg::CMD_CLK_EN] || sw_trig)) begin
            nxt_st.clk_on = 1'b1;
          end
          if (sw_trig) begin
            nxt_st.count = tcw_pkg::CNT_RST;
          end
        end
        tcw_pkg::ADDR_MODE: nxt_st.mode = apply_strb(st_ff.mode, st_ff.w_data, st_ff.w_strb);
        // a and b writable in waveform only
        tcw_pkg::ADDR_RA: if (wave) begin
          nxt_st.ra = wr16[15:0];
        end
        tcw_pkg::ADDR_RB: if (wave) begin
          nxt_st.rb = wr16[15:0];
        end
        tcw_pkg::ADDR_RC:   nxt_st.rc = wr16[15:0];
        tcw_pkg::ADDR_CV, tcw_pkg::ADDR_SR: nxt_st.bresp = tcw_pkg::RESP_OKAY;
        default:            nxt_st.bresp = tcw_pkg::RESP_SLVERR;
      endcase
    end
    // read channel, value sampled at the address handshake
    if (st_ff.rvalid && s_axi_rready_i) begin
      nxt_st.rvalid = 1'b0;
    end
    if (rd_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = (s_axi_araddr_i == tcw_pkg::ADDR_CTRL || s_axi_araddr_i[1:0] != 2'h0
                       || s_axi_araddr_i > tcw_pkg::ADDR_SR) ? tcw_pkg::RESP_SLVERR
                                                             : tcw_pkg::RESP_OKAY;
      if (s_axi_araddr_i == tcw_pkg::ADDR_RA) begin
        nxt_st.a_unread = 1'b0;
      end
      if (s_axi_araddr_i == tcw_pkg::ADDR_RB) begin
        nxt_st.b_unread = 1'b0;
      end
    end
    // capture loads come after a read so the load wins
    if (ld_a) begin
      nxt_st.ra       = st_ff.count;
      nxt_st.a_unread = 1'b1;
    end
    if (ld_b) begin
      nxt_st.rb       = st_ff.count;
      nxt_st.b_unread = 1'b1;
    end
    // sticky flags cleared by status read
    // same-cycle events set after the clear
    nxt_st.flags   = (sr_read ? 8'h0 : st_ff.flags) | evts;
    nxt_st.awready = !nxt_st.aw_have && !nxt_st.bvalid;
    nxt_st.wready  = !nxt_st.w_have && !nxt_st.bvalid;
    nxt_st.arready = !nxt_st.rvalid;
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff      <= '0;
      st_ff.mode <= tcw_pkg::MODE_RST;
      st_ff.oe_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // a output takes c match code
  // a output takes a match code
  assign ia.wave    = wave;
  assign ia.sw_evt  = sw_trig;
  assign ia.ext_evt = ext_evt;
  assign ia.c_evt   = c_cmp;
  assign ia.ab_evt  = a_cmp;
  assign ia.sw_act  = st_ff.mode[tcw_pkg::MODE_S_A +: 2];
  assign ia.ext_act = st_ff.mode[tcw_pkg::MODE_E_A +: 2];
  assign ia.c_act   = st_ff.mode[tcw_pkg::MODE_C_A +: 2];
  assign ia.ab_act  = st_ff.mode[tcw_pkg::MODE_A_A +: 2];
  // b output takes b match code
  // b output takes c match code
  assign ib.wave    = wave;
  assign ib.sw_evt  = sw_trig;
  assign ib.ext_evt = ext_evt;
  assign ib.c_evt   = c_cmp;
  assign ib.ab_evt  = b_cmp;
  assign ib.sw_act  = st_ff.mode[tcw_pkg::MODE_S_B +: 2];
  assign ib.ext_act = st_ff.mode[tcw_pkg::MODE_E_B +: 2];
  assign ib.c_act   = st_ff.mode[tcw_pkg::MODE_C_B +: 2];
  assign ib.ab_act  = st_ff.mode[tcw_pkg::MODE_B_B +: 2];

  // one driver per output pin
  tcw_out_ctl u_out_a (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .act_if(ia));
  tcw_out_ctl u_out_b (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .act_if(ib));

  // outputs straight from flops
  assign s_axi_awready_o   = st_ff.awready;
  assign s_axi_wready_o    = st_ff.wready;
  assign s_axi_bresp_o     = st_ff.bresp;
  assign s_axi_bvalid_o    = st_ff.bvalid;
  assign s_axi_arready_o   = st_ff.arready;
  assign s_axi_rdata_o     = st_ff.rdata;
  assign s_axi_rresp_o     = st_ff.rresp;
  assign s_axi_rvalid_o    = st_ff.rvalid;
  assign wave_out_a_o      = ia.level;
  assign wave_out_b_o      = ib.level;
  assign wave_out_a_oe_n_o = st_ff.oe_n;
  assign wave_out_b_oe_n_o = st_ff.oe_n;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_ovf_set;
    ovf_evt |=> st_ff.flags[tcw_pkg::SR_OVF] && st_ff.count == tcw_pkg::CNT_RST;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_sr_race;
    sr_read && c_cmp |=> st_ff.flags[tcw_pkg::SR_CPC];
  endproperty
  a_sr_race: assert property (p_sr_race) else $error("event lost at status read");

  property p_sr_clear;
    sr_read && !ext_evt |=> !st_ff.flags[tcw_pkg::SR_ETRG];
  endproperty
  a_sr_clear: assert property (p_sr_clear) else $error("flag not cleared by read");

  property p_cv_read;
    rd_fire && s_axi_araddr_i == tcw_pkg::ADDR_CV |=>
      s_axi_rvalid_o && s_axi_rdata_o == {16'h0, $past(st_ff.count)};
  endproperty
  a_cv_read: assert property (p_cv_read) else $error("count readback wrong");

  property p_ra_capt;
    wr_fire && !wave && st_ff.aw_addr == tcw_pkg::ADDR_RA && !ld_a |=> $stable(st_ff.ra);
  endproperty
  a_ra_capt: assert property (p_ra_capt) else $error("a written in capture");

  sequence s_rc_write;
    wr_fire && st_ff.aw_addr == tcw_pkg::ADDR_RC && st_ff.w_strb == 4'hf;
  endsequence
  property p_rc_write;
    logic [15:0] v;
    (s_rc_write, v = st_ff.w_data[15:0]) |=> st_ff.rc == v ##0 s_axi_bvalid_o;
  endproperty
  a_rc_write: assert property (p_rc_write) else $error("c write lost");

  property p_lovr;
    lovr_evt |-> !wave ##1 st_ff.flags[tcw_pkg::SR_LOVR];
  endproperty
  a_lovr: assert property (p_lovr) else $error("overrun not flagged");

  property p_capt_mask;
    !wave |-> rd_val[tcw_pkg::SR_CPB:tcw_pkg::SR_CPA] == 2'h0 || s_axi_araddr_i != tcw_pkg::ADDR_SR;
  endproperty
  a_capt_mask: assert property (p_capt_mask) else $error("match flags visible in capture");

  property p_ld_flag;
    ld_b |=> st_ff.flags[tcw_pkg::SR_LDB] && st_ff.b_unread;
  endproperty
  a_ld_flag: assert property (p_ld_flag) else $error("b load not flagged");

  property p_clkon;
    sr_read |=> s_axi_rdata_o[tcw_pkg::SR_CLKON] == $past(st_ff.clk_on)
      && s_axi_rdata_o[tcw_pkg::SR_MIRA] == $past(mir_a);
  endproperty
  a_clkon: assert property (p_clkon) else $error("clock status wrong");
endmodule

// ---- pkg/tcw_pkg.sv ----
// constants and field layout of the timer channel
package tcw_pkg;
  // register byte addresses
  localparam int             ADDR_W      = 8;
  localparam logic [7:0]     ADDR_CTRL   = 8'h00;
  localparam logic [7:0]     ADDR_MODE   = 8'h04;
  localparam logic [7:0]     ADDR_CV     = 8'h10;
  localparam logic [7:0]     ADDR_RA     = 8'h14;
  localparam logic [7:0]     ADDR_RB     = 8'h18;
  localparam logic [7:0]     ADDR_RC     = 8'h1c;
  localparam logic [7:0]     ADDR_SR     = 8'h20;
  // command bits of the control word
  localparam int             CMD_CLK_EN  = 0;
  localparam int             CMD_CLK_DIS = 1;
  localparam int             CMD_SW_TRIG = 2;
  // mode word fields, low bit of each 2-bit field; the wave bit is a single bit
  localparam int             MODE_LDA    = 0;
  localparam int             MODE_LDB    = 2;
  localparam int             MODE_EXT    = 4;
  localparam int             MODE_WAVE   = 15;
  localparam int             MODE_A_A    = 16;
  localparam int             MODE_C_A    = 18;
  localparam int             MODE_E_A    = 20;
  localparam int             MODE_S_A    = 22;
  localparam int             MODE_B_B    = 24;
  localparam int             MODE_C_B    = 26;
  localparam int             MODE_E_B    = 28;
  localparam int             MODE_S_B    = 30;
  // status word bit positions
  localparam int             SR_OVF      = 0;
  localparam int             SR_LOVR     = 1;
  localparam int             SR_CPA      = 2;
  localparam int             SR_CPB      = 3;
  localparam int             SR_CPC      = 4;
  localparam int             SR_LDA      = 5;
  localparam int             SR_LDB      = 6;
  localparam int             SR_ETRG     = 7;
  localparam int             SR_CLKON    = 16;
  localparam int             SR_MIRA     = 17;
  localparam int             SR_MIRB     = 18;
  // flags that only live in one mode
  localparam logic [7:0]     FLG_WAVE_ONLY = 8'h0c;
  localparam logic [7:0]     FLG_CAPT_ONLY = 8'h62;
  // reset values and limits
  localparam logic [31:0]    MODE_RST    = 32'h0;
  localparam logic [15:0]    CNT_RST     = 16'h0;
  localparam logic [15:0]    CNT_MAX     = 16'hffff;
  localparam logic [15:0]    CNT_ONE     = 16'h1;
  // bus answers
  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_SLVERR = 2'h2;
  // output action and edge select codes
  localparam logic [1:0]     ACT_NONE    = 2'h0;
  localparam logic [1:0]     ACT_SET     = 2'h1;
  localparam logic [1:0]     ACT_CLR     = 2'h2;
  localparam logic [1:0]     ACT_TGL     = 2'h3;
  localparam logic [1:0]     EDGE_NONE   = 2'h0;
  localparam logic [1:0]     EDGE_RISE   = 2'h1;
  localparam logic [1:0]     EDGE_FALL   = 2'h2;
  localparam logic [1:0]     EDGE_BOTH   = 2'h3;
endpackage

// ---- pkg/tcw_act_if.sv ----
// events and action codes passed to one output driver
`timescale 1ns/1ps
interface tcw_act_if;
  logic       wave;
  logic       sw_evt;
  logic       ext_evt;
  logic       c_evt;
  logic       ab_evt;
  logic [1:0] sw_act;
  logic [1:0] ext_act;
  logic [1:0] c_act;
  logic [1:0] ab_act;
  logic       level;
  modport drv (output wave, sw_evt, ext_evt, c_evt, ab_evt,
               output sw_act, ext_act, c_act, ab_act, input level);
  modport act (input wave, sw_evt, ext_evt, c_evt, ab_evt,
               input sw_act, ext_act, c_act, ab_act, output level);
endinterface

// ---- hdl/tcw_out_ctl.sv ----
// output pin driver: picks one event per cycle and applies its action
`timescale 1ns/1ps
module tcw_out_ctl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // events and codes from the channel
  tcw_act_if.act   act_if
);
  typedef struct packed {
    logic level;
  } tcw_out_st_t;

  tcw_out_st_t st_ff;
  tcw_out_st_t nxt_st;
  logic [1:0]  code;

  function automatic logic apply_act(input logic [1:0] c, input logic cur);
    unique case (c)
      tcw_pkg::ACT_NONE: apply_act = cur;
      tcw_pkg::ACT_SET:  apply_act = 1'b1;
      tcw_pkg::ACT_CLR:  apply_act = 1'b0;
      tcw_pkg::ACT_TGL:  apply_act = ~cur;
    endcase
  endfunction

  // highest event wins even if its code is none, so a lower one never leaks through
  always_comb begin
    nxt_st = st_ff;
    code   = tcw_pkg::ACT_NONE;
    if (act_if.sw_evt) begin
      code = act_if.sw_act;
    end else if (act_if.ext_evt) begin
      code = act_if.ext_act;
    end else if (act_if.c_evt) begin
      code = act_if.c_act;
    end else if (act_if.ab_evt) begin
      code = act_if.ab_act;
    end
    if (act_if.wave) begin
      nxt_st.level = apply_act(code, st_ff.level);
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign act_if.level = st_ff.level;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_prio_sw;
    act_if.wave && act_if.sw_evt && act_if.ext_evt && act_if.sw_act == tcw_pkg::ACT_SET
      && act_if.ext_act == tcw_pkg::ACT_CLR |=> act_if.level;
  endproperty
  a_prio_sw: assert property (p_prio_sw) else $error("sw trigger lost priority");

  property p_cmp_tgl;
    act_if.wave && act_if.c_evt && !act_if.sw_evt && !act_if.ext_evt
      && act_if.c_act == tcw_pkg::ACT_TGL |=> act_if.level != $past(act_if.level);
  endproperty
  a_cmp_tgl: assert property (p_cmp_tgl) else $error("compare toggle missed");

  property p_capt_hold;
    !act_if.wave |=> $stable(act_if.level);
  endproperty
  a_capt_hold: assert property (p_capt_hold) else $error("level moved in capture");
endmodule

// ---- testbench/tcw_pin_model.sv ----
// far-side model of one channel pin
`timescale 1ns/1ps
module tcw_pin_model (
  // device side
  input  wire logic oe_n_i,
  input  wire logic drv_i,
  // far-side level
  input  wire logic far_i,
  // resolved pin
  output logic      pin_o
);
  // far side drives only once the device lets go, so no contention
  assign pin_o = oe_n_i ? far_i : drv_i;
endmodule

// ---- testbench/test_timer_channel_output_status.sv ----
// self-checking bench for the timer channel
`timescale 1ns/1ps
module test_timer_channel_output_status;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, ea;
  logic [1:0]  bresp, rresp, resp;
  logic        far_a = 1'b0, far_b = 1'b0, ext_trig = 1'b0;
  logic        out_a, oe_n_a, out_b, oe_n_b, pin_a, pin_b;
  int          n_mismatch = 0, samples_checked = 0;
  // 250 MHz system clock
  always #2 clk_sys_i = ~clk_sys_i;
  tcw_channel dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .wave_out_a_i(pin_a),
    .wave_out_a_o(out_a), .wave_out_a_oe_n_o(oe_n_a), .wave_out_b_i(pin_b),
    .wave_out_b_o(out_b), .wave_out_b_oe_n_o(oe_n_b), .ext_trig_i(ext_trig));
  tcw_pin_model pm_a (.oe_n_i(oe_n_a), .drv_i(out_a), .far_i(far_a), .pin_o(pin_a));
  tcw_pin_model pm_b (.oe_n_i(oe_n_b), .drv_i(out_b), .far_i(far_b), .pin_o(pin_b));
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // a bus wait that ran out ends the run
  task automatic limit(input int n);
    if (n >= 50) begin
      n_mismatch++;
      $display("unexpected at %0t: bus wait ran out", $time);
      summarize();
    end
  endtask
  // one write; ready is looked at mid-cycle, released after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    @(posedge clk_sys_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // local taken flags: the valids only change after this edge, so they cannot end the loop
    for (n = 0; n < 50 && !(ha && hw); n++) begin
      @(negedge clk_sys_i);
      ha = ha | awready;
      hw = hw | wready;
      @(posedge clk_sys_i);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    limit(n);
    for (n = 0; n < 50 && !bvalid; n++) @(negedge clk_sys_i);
    limit(n);
    resp = bresp;
    @(posedge clk_sys_i);
    bready <= 1'b0;
  endtask
  // one read
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_sys_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && !(arvalid && arready); n++) @(negedge clk_sys_i);
    limit(n);
    @(posedge clk_sys_i);
    arvalid <= 1'b0;
    for (n = 0; n < 50 && !rvalid; n++) @(negedge clk_sys_i);
    limit(n);
    got = rdata;
    resp = rresp;
    @(posedge clk_sys_i);
    rready <= 1'b0;
  endtask
  // register access after reset, clock still off
  task automatic t_regs();
    wr(tcw_pkg::ADDR_RC, 32'h0000_1234);
    chk(resp, tcw_pkg::RESP_OKAY);
    rd(tcw_pkg::ADDR_RC);
    chk(got, 32'h0000_1234);
    wr(tcw_pkg::ADDR_CV, 32'h0000_00ff);
    rd(tcw_pkg::ADDR_CV);
    chk(got, 32'h0);
    rd(tcw_pkg::ADDR_SR);
    chk(got, 32'h0);
    rd(8'h40);
    chk({got[29:0], resp}, {30'h0, tcw_pkg::RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk(resp, tcw_pkg::RESP_SLVERR);
    $display("t_regs done");
  endtask
  // capture: loads from pin a edges, overrun, external trigger
  task automatic t_capture();
    logic [31:0] ra;
    wr(tcw_pkg::ADDR_CTRL, 32'h1);
    wr(tcw_pkg::ADDR_MODE, 32'h0000_0011);
    rd(tcw_pkg::ADDR_RA);
    ra = got;
    wr(tcw_pkg::ADDR_RA, 32'h0000_5555);
    rd(tcw_pkg::ADDR_RA);
    chk(got, ra);
    // two rising edges on pin a and on the trigger, no read of a between
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      far_a <= ~far_a;
      ext_trig <= ~ext_trig;
      repeat (10) @(posedge clk_sys_i);
    end
    rd(tcw_pkg::ADDR_SR);
    chk(got, 32'h0001_00a2);
    rd(tcw_pkg::ADDR_SR);
    chk(got, 32'h0001_0000);
    $display("t_capture done");
  endtask
  // software trigger with every action code on both outputs
  task automatic t_soft();
    logic [1:0] cd [5] = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0};
    ea = 1'b0;
    foreach (cd[i]) begin
      wr(tcw_pkg::ADDR_MODE, 32'h0000_8000 | {cd[i], 6'h0, cd[i], 22'h0});
      wr(tcw_pkg::ADDR_CTRL, 32'h4);
      ea = (cd[i] == 2'h1) ? 1'b1 : (cd[i] == 2'h2) ? 1'b0 : (cd[i] == 2'h3) ? ~ea : ea;
      @(negedge clk_sys_i);
      chk({oe_n_a, oe_n_b, out_a, out_b}, {2'b00, ea, ea});
      rd(tcw_pkg::ADDR_SR);
      chk(got[18:16], {ea, ea, 1'b1});
    end
    $display("t_soft done");
  endtask
  // compare matches on a, b and c in waveform mode
  task automatic t_match();
    wr(tcw_pkg::ADDR_CTRL, 32'h2);
    wr(tcw_pkg::ADDR_RA, 32'h0000_0010);
    wr(tcw_pkg::ADDR_RB, 32'h0000_0020);
    wr(tcw_pkg::ADDR_RC, 32'h0000_0030);
    wr(tcw_pkg::ADDR_MODE, 32'h0301_8000);
    rd(tcw_pkg::ADDR_SR);
    wr(tcw_pkg::ADDR_CTRL, 32'h4);
    repeat (100) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({out_a, out_b}, 2'b11);
    rd(tcw_pkg::ADDR_SR);
    chk(got, 32'h0007_001c);
    rd(tcw_pkg::ADDR_CV);
    chk(got[31:16], 16'h0);
    // external rising edge: a cleared, b toggled, compares long past
    wr(tcw_pkg::ADDR_MODE, 32'h3321_8010);
    @(posedge clk_sys_i);
    ext_trig <= 1'b1;
    repeat (10) @(negedge clk_sys_i);
    chk({out_a, out_b}, 2'b00);
    $display("t_match done");
  endtask
  // full wrap: overflow flag, c match toggles a and sets b
  task automatic t_ovf();
    wr(tcw_pkg::ADDR_MODE, 32'h040c_8000);
    wr(tcw_pkg::ADDR_CTRL, 32'h4);
    rd(tcw_pkg::ADDR_SR);
    // read lands before the c match of the next lap
    repeat (65536) @(posedge clk_sys_i);
    rd(tcw_pkg::ADDR_SR);
    @(negedge clk_sys_i);
    chk({got[0], out_a, out_b}, 3'b111);
    rd(tcw_pkg::ADDR_SR);
    chk(got[0], 1'b0);
    $display("t_ovf done");
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    t_regs();
    t_capture();
    t_soft();
    t_match();
    t_ovf();
    summarize();
  end
endmodule
